// file: logic/imc_defines.svh
`ifndef IMC_DEFINES_SVH
`define IMC_DEFINES_SVH
`define IMC_CLK_PERIOD_NS 50
`define IMC_TICK_NS 100_000_000
`define IMC_TICK_CYCLES (`IMC_TICK_NS / `IMC_CLK_PERIOD_NS)
`define IMC_T_INIT_MIN_DS 16'h000A
`define IMC_T_BOOT_DS 16'h0258
`define IMC_T_ACT_DS 16'h044C
`define IMC_T_SLOW_DS 16'h0500
`define IMC_T_SCI_DS 16'h0020
`define IMC_T_OBS_HK_DS 16'h0080
`define IMC_PKT_MIN 7'h0C
`define IMC_PKT_MAX 7'h60
`define IMC_PKT_LAST 2'h3
`define IMC_TOK_WIN 8'h3F
`define IMC_DEF_COOLER 1'b1
`define IMC_PC_PWR_ON 0
`define IMC_PC_PWR_OFF 1
`define IMC_PC_COOL_ON 2
`define IMC_PC_COOL_OFF 3
`define IMC_PC_MAIN_EN 4
`define IMC_PC_SPARE_EN 5
`endif

// file: logic/imc_pkg.sv
package imc_pkg;
  typedef enum logic [2:0] {
    MODE_BOOT = 3'b000,
    MODE_UPLOAD = 3'b001,
    MODE_INIT = 3'b010,
    MODE_PREOBS = 3'b011,
    MODE_OBS = 3'b100,
    MODE_OUTGAS = 3'b101
  } imc_mode_t;
  typedef enum logic [1:0] {
    LINK_READY = 2'b00,
    LINK_NULL = 2'b01,
    LINK_UP = 2'b10,
    LINK_FAIL = 2'b11
  } imc_link_t;
  typedef enum logic [1:0] {
    TOK_IDLE = 2'b00,
    TOK_NULL = 2'b01,
    TOK_FCC = 2'b10,
    TOK_DATA = 2'b11
  } imc_tok_t;
  typedef enum logic [3:0] {
    TC_INIT = 4'b0000,
    TC_START = 4'b0001,
    TC_RESUME = 4'b0010,
    TC_STANDBY = 4'b0011,
    TC_STOP = 4'b0100,
    TC_HS_START = 4'b0101,
    TC_SCI_STOP = 4'b0110,
    TC_TIME_UPD = 4'b0111
  } imc_tc_t;
  typedef enum logic [1:0] {
    INIT_NORMAL = 2'b00,
    INIT_UPLOAD = 2'b01,
    INIT_OUTGAS = 2'b10
  } imc_init_t;
  typedef enum logic [2:0] {
    REP_HK = 3'b000,
    REP_LOW_SCI = 3'b001,
    REP_ACCEPT = 3'b010,
    REP_STOPPED = 3'b011,
    REP_ANOMALY = 3'b100
  } imc_rep_t;
endpackage

// file: logic/imc_link_if.sv
`timescale 1ns/1ns
interface imc_link_if;
  import imc_pkg::*;
  logic tcValid;
  imc_tc_t tcCode;
  logic [15:0] tcArg;
  logic tcLine;
  logic syncPulse;
  logic [1:0] nomActive;
  logic [1:0] redActive;
  logic nominalPowerOnPulse;
  logic nominalPowerOffPulse;
  logic nominalCoolerOnPulse;
  logic nominalCoolerOffPulse;
  logic nominalLineMainBoardEnable;
  logic nominalLineSpareBoardEnable;
  imc_tok_t craftTok;
  logic craftReady;
  imc_tok_t instTok;
  logic [7:0] instData;
  logic tmValid;
  imc_rep_t tmKind;
  modport inst (
    input tcValid, tcCode, tcArg, tcLine, syncPulse, nomActive, redActive,
    input nominalPowerOnPulse, nominalPowerOffPulse, nominalCoolerOnPulse, nominalCoolerOffPulse,
    input nominalLineMainBoardEnable, nominalLineSpareBoardEnable, craftTok, craftReady,
    output instTok, instData, tmValid, tmKind
  );
  modport craft (
    output tcValid, tcCode, tcArg, tcLine, syncPulse, nomActive, redActive,
    output nominalPowerOnPulse, nominalPowerOffPulse, nominalCoolerOnPulse, nominalCoolerOffPulse,
    output nominalLineMainBoardEnable, nominalLineSpareBoardEnable, craftTok, craftReady,
    input instTok, instData, tmValid, tmKind
  );
endinterface

// file: logic/imc_skid_buf.sv
`timescale 1ns/1ns
module imc_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_reg [2];
  logic wrPtr_reg;
  logic rdPtr_reg;
  logic [1:0] count_reg;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  assign inReady = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData = mem_reg[rdPtr_reg];
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= !wrPtr_reg;
      end
      if (doRead) begin
        rdPtr_reg <= !rdPtr_reg;
      end
      count_reg <= count_reg + {1'b0, doWrite} - {1'b0, doRead};
    end
  end
  // Storage needs no reset; count guards every read
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end
endmodule

// file: logic/imc_craft.sv
`timescale 1ns/1ns
`include "imc_defines.svh"
module imc_craft (
  input wire logic clk_sys,
  input wire logic reset,
  imc_link_if.craft link,
  input wire logic tcSend,
  input imc_pkg::imc_tc_t tcCodeIn,
  input wire logic [15:0] tcArgIn,
  input wire logic tcLineIn,
  input wire logic syncReq,
  input wire logic [5:0] pulseReq,
  input wire logic [1:0] nomActiveIn,
  input wire logic [1:0] redActiveIn,
  input wire logic hsReady,
  output logic [7:0] hsWord,
  output logic hsWordValid,
  output logic craftUp,
  output logic tmSeen,
  output imc_pkg::imc_rep_t tmSeenKind
);
  import imc_pkg::*;
  logic up_reg;
  logic alt_reg;
  logic stopPend_reg;
  wire gotNull = (link.instTok == TOK_NULL);
  wire gotStopped = link.tmValid && (link.tmKind == REP_STOPPED);
  wire stopSent = tcSend && (tcCodeIn == TC_SCI_STOP);
  wire closeLink = up_reg && stopPend_reg && gotStopped;
  wire upNext = closeLink ? 1'b0 : (up_reg || gotNull);
  assign craftUp = up_reg;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      up_reg <= 1'b0;
      alt_reg <= 1'b0;
      stopPend_reg <= 1'b0;
      link.craftTok <= TOK_IDLE;
    end else begin
      up_reg <= upNext;
      alt_reg <= upNext && !alt_reg;
      stopPend_reg <= stopSent || (stopPend_reg && !closeLink);
      link.craftTok <= !upNext ? TOK_IDLE : (alt_reg ? TOK_FCC : TOK_NULL);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link.tcValid <= 1'b0;
      link.tcCode <= TC_INIT;
      link.tcArg <= 16'h0000;
      link.tcLine <= 1'b0;
      link.syncPulse <= 1'b0;
      link.nomActive <= 2'h0;
      link.redActive <= 2'h0;
      link.nominalPowerOnPulse <= 1'b0;
      link.nominalPowerOffPulse <= 1'b0;
      link.nominalCoolerOnPulse <= 1'b0;
      link.nominalCoolerOffPulse <= 1'b0;
      link.nominalLineMainBoardEnable <= 1'b0;
      link.nominalLineSpareBoardEnable <= 1'b0;
      link.craftReady <= 1'b0;
      hsWord <= 8'h00;
      hsWordValid <= 1'b0;
      tmSeen <= 1'b0;
      tmSeenKind <= REP_HK;
    end else begin
      link.tcValid <= tcSend;
      link.tcCode <= tcCodeIn;
      link.tcArg <= tcArgIn;
      link.tcLine <= tcLineIn;
      link.syncPulse <= syncReq;
      link.nomActive <= nomActiveIn;
      link.redActive <= redActiveIn;
      link.nominalPowerOnPulse <= pulseReq[`IMC_PC_PWR_ON];
      link.nominalPowerOffPulse <= pulseReq[`IMC_PC_PWR_OFF];
      link.nominalCoolerOnPulse <= pulseReq[`IMC_PC_COOL_ON];
      link.nominalCoolerOffPulse <= pulseReq[`IMC_PC_COOL_OFF];
      link.nominalLineMainBoardEnable <= pulseReq[`IMC_PC_MAIN_EN];
      link.nominalLineSpareBoardEnable <= pulseReq[`IMC_PC_SPARE_EN];
      link.craftReady <= hsReady;
      hsWord <= link.instData;
      hsWordValid <= (link.instTok == TOK_DATA);
      tmSeen <= link.tmValid;
      tmSeenKind <= link.tmKind;
    end
  end
endmodule

// file: logic/imc_instrument.sv
`timescale 1ns/1ns
`include "imc_defines.svh"
// Operation
// - Craft sends init command within 1..60 s
// - At 60 s leave boot unless upload
// - Activate init at 110 s, else default
// - Keep only the last init command
// - Activation goes pre-observation or outgassing, locked
// - Pre-observation: coolers, reports every 128 s
// - Observation: 12..96 packets/3.2 s, report/12.8 s
// - Outgassing: no science, report every 128 s
// - Pick active remote line for commands and telemetry; the code gates only commands by it
// - Line choice kept per processing board
// - Far end ready, awaiting null tokens
// - After power-on link ready, no tokens
// - Start-link command begins null tokens
// - Far end answers nulls with fcc and null
// - Null received: send fcc and null, up
// - Check tokens; send science while good
// - Check fails: stop tokens, report anomaly
// - Stop science at packet boundary, report stopped
// - Stop command: accept, stopped, far end closes
// - Time update takes effect on sync pulse
// - Separate discrete pulses for power, cooler, boards
// - High-speed data only in observation
// - Observation entered/left only by four commands; science stop also leaves it
module imc_instrument #(
  parameter int TICK_CYCLES = `IMC_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  imc_link_if.inst link,
  output imc_pkg::imc_mode_t mode,
  output imc_pkg::imc_link_t linkState,
  output logic coolerOn,
  output logic heaterOn,
  output logic [1:0] lineSelRed,
  output logic activeBoard,
  output logic [15:0] obtTime
);
  import imc_pkg::*;
  logic [31:0] tickCnt_reg;
  logic tick_reg;
  logic [15:0] secCnt_reg;
  imc_mode_t mode_reg;
  imc_mode_t modeNext;
  imc_link_t link_reg;
  imc_link_t linkNext;
  logic initSeen_reg;
  imc_init_t initKind_reg;
  logic initCooler_reg;
  logic coolerCfg_reg;
  logic coolerPwr_reg;
  logic [1:0] selRed_reg;
  logic board_reg;
  logic [15:0] perCnt_reg;
  logic [15:0] sciCnt_reg;
  logic [6:0] nPkt_reg;
  logic [6:0] pktLeft_reg;
  logic [1:0] wordIdx_reg;
  logic [5:0] pktSeq_reg;
  logic stopPend_reg;
  logic sciEnd_reg;
  logic [7:0] winCnt_reg;
  logic seenF_reg;
  logic seenN_reg;
  logic alt_reg;
  logic [4:0] pend_reg;
  logic [4:0] pick;
  logic [2:0] pickIdx;
  logic pickAny;
  logic timePend_reg;
  logic [15:0] timeVal_reg;
  logic bufInReady;
  logic bufOutValid;
  logic [7:0] bufOutData;

  wire tickWrap = (tickCnt_reg == 32'(TICK_CYCLES - 1));
  wire tcOk = link.tcValid && (link.tcLine == selRed_reg[board_reg]);
  wire privOk = tcOk && (mode_reg != MODE_OUTGAS);
  wire tcInit = tcOk && (link.tcCode == TC_INIT) && (mode_reg == MODE_BOOT);
  wire tcGo = privOk && ((link.tcCode == TC_START) || (link.tcCode == TC_RESUME));
  wire tcHalt = privOk && ((link.tcCode == TC_STANDBY) || (link.tcCode == TC_STOP));
  wire tcSciStop = privOk && (link.tcCode == TC_SCI_STOP);
  wire tcHsStart = privOk && (link.tcCode == TC_HS_START);
  wire tcTime = tcOk && (link.tcCode == TC_TIME_UPD);
  wire bootDone = (secCnt_reg >= `IMC_T_BOOT_DS);
  wire actDone = (secCnt_reg >= `IMC_T_ACT_DS);
  wire isObs = (mode_reg == MODE_OBS);
  wire isPre = (mode_reg == MODE_PREOBS);
  wire periodic = isPre || isObs || (mode_reg == MODE_OUTGAS);
  wire [15:0] hkLast = (isObs ? `IMC_T_OBS_HK_DS : `IMC_T_SLOW_DS) - 16'h0001;
  wire hkEvt = periodic && tick_reg && (perCnt_reg == hkLast);
  wire lowSciEvt = hkEvt && isPre;
  wire sciEvt = isObs && tick_reg && (sciCnt_reg == `IMC_T_SCI_DS - 16'h0001);
  wire linkUp = (link_reg == LINK_UP);
  wire boundary = (wordIdx_reg == 2'h0) || !linkUp;
  wire stopDone = isObs && stopPend_reg && boundary;
  wire genGo = isObs && linkUp && ((wordIdx_reg != 2'h0) || ((pktLeft_reg != 7'h00) && !stopPend_reg));
  wire push = genGo && bufInReady;
  wire winEnd = linkUp && (winCnt_reg == `IMC_TOK_WIN);
  wire tokBad = winEnd && !(seenF_reg && seenN_reg);
  wire sendData = linkUp && isObs && bufOutValid && link.craftReady;
  wire [6:0] argPkt = link.tcArg[6:0];
  wire [6:0] pktClamp = (argPkt < `IMC_PKT_MIN) ? `IMC_PKT_MIN : ((argPkt > `IMC_PKT_MAX) ? `IMC_PKT_MAX : argPkt);
  wire [4:0] newEv = {tokBad, stopDone, tcSciStop, lowSciEvt, hkEvt};

  imc_skid_buf #(
    .WIDTH(8)
  ) sciBuf (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(genGo),
    .inData({pktSeq_reg, wordIdx_reg}),
    .inReady(bufInReady),
    .outValid(bufOutValid),
    .outReady(sendData),
    .outData(bufOutData)
  );

  always_comb begin
    modeNext = mode_reg;
    unique case (mode_reg)
      MODE_BOOT: if (bootDone) modeNext = (initSeen_reg && initKind_reg == INIT_UPLOAD) ? MODE_UPLOAD : MODE_INIT;
      MODE_UPLOAD: modeNext = MODE_UPLOAD;
      MODE_INIT: if (actDone) modeNext = (initSeen_reg && initKind_reg == INIT_OUTGAS) ? MODE_OUTGAS : MODE_PREOBS;
      MODE_PREOBS: if (tcGo) modeNext = MODE_OBS;
      MODE_OBS: if (stopDone) modeNext = MODE_PREOBS;
      MODE_OUTGAS: modeNext = MODE_OUTGAS;
      default: modeNext = MODE_BOOT;
    endcase
  end

  always_comb begin
    linkNext = link_reg;
    unique case (link_reg)
      LINK_READY: if (tcHsStart) linkNext = LINK_NULL;
      LINK_NULL: if (link.craftTok == TOK_NULL) linkNext = LINK_UP;
      LINK_UP: begin
        if (tokBad) begin
          linkNext = LINK_FAIL;
        end else if (stopDone && (sciEnd_reg || tcSciStop)) begin
          // Only a science stop closes; the far end keeps tokens up across stand-by
          linkNext = LINK_READY;
        end
      end
      LINK_FAIL: if (tcHsStart) linkNext = LINK_NULL;
    endcase
  end

  // Lowest pending report first, so acceptance precedes stopped
  always_comb begin
    pick = 5'h00;
    pickIdx = 3'h0;
    pickAny = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (pend_reg[i] && !pickAny) begin
        pick[i] = 1'b1;
        pickIdx = 3'(i);
        pickAny = 1'b1;
      end
    end
  end

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : gLine
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          selRed_reg[b] <= 1'b0;
        end else if (selRed_reg[b]) begin
          selRed_reg[b] <= !(!link.redActive[b] && link.nomActive[b]);
        end else begin
          selRed_reg[b] <= !link.nomActive[b] && link.redActive[b];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tickCnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
      secCnt_reg <= 16'h0000;
      mode_reg <= MODE_BOOT;
      link_reg <= LINK_READY;
      board_reg <= 1'b0;
      coolerPwr_reg <= 1'b0;
    end else begin
      tickCnt_reg <= tickWrap ? 32'h0000_0000 : tickCnt_reg + 32'h0000_0001;
      tick_reg <= tickWrap;
      if (tick_reg && secCnt_reg != 16'hFFFF) begin
        secCnt_reg <= secCnt_reg + 16'h0001;
      end
      mode_reg <= modeNext;
      link_reg <= linkNext;
      if (link.nominalLineMainBoardEnable) begin
        board_reg <= 1'b0;
      end else if (link.nominalLineSpareBoardEnable) begin
        board_reg <= 1'b1;
      end
      if (link.nominalCoolerOnPulse) begin
        coolerPwr_reg <= 1'b1;
      end else if (link.nominalCoolerOffPulse) begin
        coolerPwr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      initSeen_reg <= 1'b0;
      initKind_reg <= INIT_NORMAL;
      initCooler_reg <= 1'b0;
      coolerCfg_reg <= 1'b0;
    end else begin
      if (tcInit && !bootDone) begin
        initSeen_reg <= 1'b1;
        initKind_reg <= imc_init_t'(link.tcArg[1:0]);
        initCooler_reg <= link.tcArg[2];
      end
      if (mode_reg == MODE_INIT && actDone) begin
        coolerCfg_reg <= initSeen_reg ? initCooler_reg : `IMC_DEF_COOLER;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || mode_reg != modeNext) begin
      perCnt_reg <= 16'h0000;
      sciCnt_reg <= 16'h0000;
    end else if (tick_reg) begin
      perCnt_reg <= (perCnt_reg == hkLast) ? 16'h0000 : perCnt_reg + 16'h0001;
      sciCnt_reg <= sciEvt ? 16'h0000 : sciCnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !isObs) begin
      pktLeft_reg <= 7'h00;
      wordIdx_reg <= 2'h0;
      stopPend_reg <= 1'b0;
      sciEnd_reg <= 1'b0;
    end else begin
      sciEnd_reg <= tcSciStop || sciEnd_reg;
      if (sciEvt) begin
        pktLeft_reg <= nPkt_reg;
      end else if (push && wordIdx_reg == 2'h0) begin
        pktLeft_reg <= pktLeft_reg - 7'h01;
      end
      if (push) begin
        wordIdx_reg <= (wordIdx_reg == `IMC_PKT_LAST) ? 2'h0 : wordIdx_reg + 2'h1;
      end
      stopPend_reg <= tcHalt || tcSciStop || (stopPend_reg && !stopDone);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nPkt_reg <= `IMC_PKT_MIN;
      pktSeq_reg <= 6'h00;
      pend_reg <= 5'h00;
      link.tmValid <= 1'b0;
      link.tmKind <= REP_HK;
    end else begin
      if (tcGo && isPre) begin
        nPkt_reg <= pktClamp;
      end
      if (push && wordIdx_reg == `IMC_PKT_LAST) begin
        pktSeq_reg <= pktSeq_reg + 6'h01;
      end
      pend_reg <= (pend_reg & ~pick) | newEv;
      link.tmValid <= pickAny;
      link.tmKind <= imc_rep_t'(pickIdx);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !linkUp) begin
      winCnt_reg <= 8'h00;
      seenF_reg <= 1'b0;
      seenN_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else begin
      winCnt_reg <= winEnd ? 8'h00 : winCnt_reg + 8'h01;
      seenF_reg <= (link.craftTok == TOK_FCC) || (seenF_reg && !winEnd);
      seenN_reg <= (link.craftTok == TOK_NULL) || (seenN_reg && !winEnd);
      alt_reg <= sendData ? alt_reg : !alt_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link.instTok <= TOK_IDLE;
      link.instData <= 8'h00;
    end else begin
      unique case (linkNext)
        LINK_NULL: link.instTok <= TOK_NULL;
        LINK_UP: link.instTok <= sendData ? TOK_DATA : (alt_reg ? TOK_FCC : TOK_NULL);
        default: link.instTok <= TOK_IDLE;
      endcase
      link.instData <= bufOutData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timePend_reg <= 1'b0;
      timeVal_reg <= 16'h0000;
      obtTime <= 16'h0000;
    end else begin
      if (tcTime) begin
        timeVal_reg <= link.tcArg;
      end
      timePend_reg <= (tcTime || timePend_reg) && !link.syncPulse;
      if (link.syncPulse && (timePend_reg || tcTime)) begin
        obtTime <= tcTime ? link.tcArg : timeVal_reg;
      end else if (tick_reg) begin
        obtTime <= obtTime + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode <= MODE_BOOT;
      linkState <= LINK_READY;
      coolerOn <= 1'b0;
      heaterOn <= 1'b0;
      lineSelRed <= 2'h0;
      activeBoard <= 1'b0;
    end else begin
      mode <= mode_reg;
      linkState <= link_reg;
      coolerOn <= coolerPwr_reg && coolerCfg_reg && (isPre || isObs);
      heaterOn <= (mode_reg == MODE_OUTGAS);
      lineSelRed <= selRed_reg;
      activeBoard <= board_reg;
    end
  end
endmodule

// file: verif/imc_link_chk.sv
`timescale 1ns/1ns
module imc_link_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tcValid,
  input imc_pkg::imc_tc_t tcCode,
  input wire logic tcLine,
  input wire logic [1:0] nomActive,
  input imc_pkg::imc_tok_t craftTok,
  input imc_pkg::imc_tok_t instTok,
  input wire logic [7:0] instData,
  input wire logic tmValid,
  input imc_pkg::imc_rep_t tmKind
);
  import imc_pkg::*;
  logic startSeen_reg, nullSeen_reg, upSeen_reg, obsCmd_reg, sciStop_reg;
  logic [1:0] lastIdx_reg;
  wire logic isData = instTok == TOK_DATA;
  wire logic isStopped = tmValid && tmKind == REP_STOPPED;
  wire logic isObsCmd = tcValid && (tcCode == TC_START || tcCode == TC_RESUME);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      startSeen_reg <= 1'b0;
      nullSeen_reg <= 1'b0;
      upSeen_reg <= 1'b0;
      obsCmd_reg <= 1'b0;
      sciStop_reg <= 1'b0;
      lastIdx_reg <= 2'h3;
    end else begin
      startSeen_reg <= startSeen_reg || (tcValid && tcCode == TC_HS_START);
      nullSeen_reg <= nullSeen_reg || instTok == TOK_NULL;
      upSeen_reg <= instTok != TOK_IDLE && (upSeen_reg || instTok == TOK_FCC || isData);
      // Only a stopped report closes it; a stand-by may still drain queued words
      obsCmd_reg <= (obsCmd_reg || isObsCmd) && !isStopped;
      sciStop_reg <= (sciStop_reg || (tcValid && tcCode == TC_SCI_STOP)) && !isStopped;
      if (isData) begin
        lastIdx_reg <= instData[1:0];
      end
    end
  end
  tok_quiet_a: assert property (!startSeen_reg |-> instTok == TOK_IDLE)
    else $error("token sent before link start");
  null_start_a: assert property (tcValid && tcCode == TC_HS_START && !tcLine && nomActive[0] && instTok == TOK_IDLE |=> instTok == TOK_NULL)
    else $error("no null token after link start");
  up_after_null_a: assert property (!upSeen_reg && (instTok == TOK_FCC || isData) |-> $past(craftTok) == TOK_NULL)
    else $error("link up without null from far end");
  packet_order_a: assert property (isData |-> instData[1:0] == lastIdx_reg + 2'h1)
    else $error("packet word index out of order");
  data_when_up_a: assert property (isData |-> upSeen_reg || $past(instTok) == TOK_NULL)
    else $error("data sent on a link that is not up");
  data_in_obs_a: assert property (isData |-> obsCmd_reg)
    else $error("data sent outside observation");
  accept_report_a: assert property (tcValid && tcCode == TC_SCI_STOP |-> ##[1:40] tmValid && tmKind == REP_ACCEPT)
    else $error("no acceptance report");
  stopped_report_a: assert property (tmValid && tmKind == REP_ACCEPT |-> ##[1:300] isStopped)
    else $error("no stopped report after acceptance");
  close_idle_a: assert property (isStopped && sciStop_reg |-> ##[0:8] instTok == TOK_IDLE)
    else $error("link not closed after stopped report");
  craft_answer_a: assert property (craftTok != TOK_IDLE |-> nullSeen_reg)
    else $error("far end tokens before any null");
  cover property (isData && instData[1:0] == 2'h3);
  cover property (!upSeen_reg ##1 upSeen_reg);
  cover property (isStopped);
endmodule

// file: verif/tb_instrument_mode_and_hs_link_control.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
`define WAITC(cond, lim) begin waitCnt = 0; while (!(cond) && waitCnt < lim) begin step(1); waitCnt++; end if (!(cond)) begin errors++; $display("unexpected wait expected done seen timeout"); conclude(); end end
module tb_instrument_mode_and_hs_link_control;
  import imc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic tcSend = 1'b0;
  imc_tc_t tcCodeIn = TC_INIT;
  logic [15:0] tcArgIn = 16'h0000;
  logic tcLineIn = 1'b0;
  logic syncReq = 1'b0;
  logic [5:0] pulseReq = 6'h00;
  logic [1:0] nomActiveIn = 2'h3;
  logic [1:0] redActiveIn = 2'h0;
  logic hsReady = 1'b1;
  logic [7:0] hsWord;
  logic hsWordValid, craftUp, tmSeen, coolerOn, heaterOn, activeBoard;
  imc_rep_t tmSeenKind;
  imc_mode_t mode, faultMode;
  imc_link_t linkState, faultLinkState;
  logic [1:0] lineSelRed;
  logic [15:0] obtTime;
  logic [31:0] rnd;
  integer errors = 0, compares = 0, seed = 32'h411b_2892, waitCnt, wordCount = 0, hkCount = 0, expWord = -1, i;
  imc_tc_t cmdTab [4] = '{TC_START, TC_STANDBY, TC_RESUME, TC_STOP};
  imc_mode_t modeTab [4] = '{MODE_OBS, MODE_PREOBS, MODE_OBS, MODE_PREOBS};
  imc_link_if link ();
  // Second link: the bench plays a far end that goes silent
  imc_link_if faultLink ();
  always #25 clk_sys = ~clk_sys;
  imc_craft imc_craft_i (.clk_sys, .reset, .link(link), .tcSend, .tcCodeIn, .tcArgIn, .tcLineIn, .syncReq,
    .pulseReq, .nomActiveIn, .redActiveIn, .hsReady, .hsWord, .hsWordValid, .craftUp, .tmSeen, .tmSeenKind);
  imc_instrument #(.TICK_CYCLES(4)) imc_instrument_i (.clk_sys, .reset, .link(link), .mode, .linkState,
    .coolerOn, .heaterOn, .lineSelRed, .activeBoard, .obtTime);
  imc_instrument #(.TICK_CYCLES(4)) spare_imc_instrument_i (.clk_sys, .reset, .link(faultLink), .mode(faultMode),
    .linkState(faultLinkState), .coolerOn(), .heaterOn(), .lineSelRed(), .activeBoard(), .obtTime());
  imc_link_chk imc_link_chk_i (.clk_sys, .reset, .tcValid(link.tcValid), .tcCode(link.tcCode), .tcLine(link.tcLine),
    .nomActive(link.nomActive), .craftTok(link.craftTok), .instTok(link.instTok), .instData(link.instData),
    .tmValid(link.tmValid), .tmKind(link.tmKind));
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic sendTc(input imc_tc_t code, input logic [15:0] arg, input logic line);
    tcSend = 1'b1;
    tcCodeIn = code;
    tcArgIn = arg;
    tcLineIn = line;
    step(1);
    tcSend = 1'b0;
    step(1);
  endtask
  task automatic conclude();
    $display("comparisons %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Word model: packet words count up as {seq, idx}, so a lost word breaks the chain
  always @(posedge clk_sys) begin
    if (!reset && hsWordValid) begin
      if (expWord < 0) begin
        expWord = {hsWord[7:2], 2'h0};
      end
      `CHK("hsWord", expWord[7:0], hsWord)
      expWord = (expWord + 1) % 256;
      wordCount++;
    end
    if (!reset && tmSeen && tmSeenKind === REP_HK) begin
      hkCount++;
    end
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    $display("unexpected run expected end seen timeout");
    conclude();
  end
  initial begin
    faultLink.tcValid = 1'b0;
    faultLink.tcCode = TC_INIT;
    faultLink.tcArg = 16'h0000;
    faultLink.tcLine = 1'b0;
    faultLink.syncPulse = 1'b0;
    faultLink.nomActive = 2'h3;
    faultLink.redActive = 2'h0;
    faultLink.nominalPowerOnPulse = 1'b0;
    faultLink.nominalPowerOffPulse = 1'b0;
    faultLink.nominalCoolerOnPulse = 1'b0;
    faultLink.nominalCoolerOffPulse = 1'b0;
    faultLink.nominalLineMainBoardEnable = 1'b0;
    faultLink.nominalLineSpareBoardEnable = 1'b0;
    faultLink.craftTok = TOK_IDLE;
    faultLink.craftReady = 1'b0;
    step(10);
    reset = 1'b0;
    `CHK("mode", MODE_BOOT, mode)
    `CHK("linkState", LINK_READY, linkState)
    faultLink.tcCode = TC_HS_START;
    faultLink.tcValid = 1'b1;
    step(1);
    faultLink.tcValid = 1'b0;
    step(1);
    for (i = 0; i < 8; i++) begin
      faultLink.craftTok = i[0] ? TOK_FCC : TOK_NULL;
      step(1);
    end
    `CHK("faultLinkState", LINK_UP, faultLinkState)
    faultLink.craftTok = TOK_IDLE;
    `WAITC(faultLink.tmValid && faultLink.tmKind === REP_ANOMALY, 300)
    `CHK("faultTok", TOK_IDLE, faultLink.instTok)
    `CHK("faultLinkState", LINK_FAIL, faultLinkState)
    rnd = $random(seed);
    // Main board enable pulsed for one cycle so later line checks stay on board 0
    pulseReq = {1'b0, 1'b1, rnd[3:0]};
    step(1);
    pulseReq = 6'h00;
    `WAITC(obtTime >= 16'h000C, 200)
    sendTc(TC_INIT, 16'h0006, 1'b0);
    sendTc(TC_INIT, 16'h0000, 1'b0);
    `WAITC(mode === MODE_INIT, 3000)
    `CHK("initTime", 1'b1, obtTime >= 16'h0258 && obtTime <= 16'h0259)
    `WAITC(mode !== MODE_INIT, 2200)
    `CHK("mode", MODE_PREOBS, mode)
    `CHK("actTime", 1'b1, obtTime >= 16'h044C && obtTime <= 16'h044D)
    `CHK("coolerOn", 1'b0, coolerOn)
    `CHK("heaterOn", 1'b0, heaterOn)
    `WAITC(tmSeen, 5300)
    `CHK("hkKind", REP_HK, tmSeenKind)
    `CHK("hkTime", 1'b1, obtTime >= 16'h094B && obtTime <= 16'h094E)
    step(1);
    `CHK("sciKind", 1'b1, tmSeen && tmSeenKind === REP_LOW_SCI)
    sendTc(TC_START, 16'h0020, 1'b1);
    step(4);
    `CHK("wrongLine", MODE_PREOBS, mode)
    sendTc(TC_HS_START, 16'h0000, 1'b0);
    `WAITC(linkState === LINK_UP && craftUp, 20)
    `CHK("linkUp", LINK_UP, linkState)
    for (i = 0; i < 4; i++) begin
      rnd = $random(seed);
      sendTc(cmdTab[i], {9'h000, rnd[6:0]}, 1'b0);
      `WAITC(mode === modeTab[i], 60)
      `CHK("modeStep", modeTab[i], mode)
      step(100);
    end
    // Below the floor of 12 packets: must be raised to 12
    sendTc(TC_START, 16'h0005, 1'b0);
    `WAITC(mode === MODE_OBS, 10)
    step(300);
    wordCount = 0;
    hkCount = 0;
    step(512);
    `CHK("wordCount", 192, wordCount)
    `CHK("hkCount", 1, hkCount)
    for (i = 0; i < 600; i++) begin
      rnd = $random(seed);
      hsReady = rnd[0];
      step(1);
    end
    hsReady = 1'b1;
    step(40);
    nomActiveIn = 2'h2;
    redActiveIn = 2'h1;
    step(6);
    `CHK("lineSelRed", 2'h1, lineSelRed)
    `CHK("activeBoard", 1'b0, activeBoard)
    sendTc(TC_SCI_STOP, 16'h0000, 1'b1);
    `WAITC(tmSeen && tmSeenKind === REP_ACCEPT, 40)
    `WAITC(tmSeen && tmSeenKind === REP_STOPPED, 300)
    `WAITC(linkState === LINK_READY && !craftUp, 20)
    `CHK("stopMode", MODE_PREOBS, mode)
    sendTc(TC_TIME_UPD, 16'h1234, 1'b1);
    step(4);
    `CHK("timeHeld", 1'b1, obtTime < 16'h1234)
    syncReq = 1'b1;
    step(1);
    syncReq = 1'b0;
    step(4);
    `CHK("timeLoaded", 1'b1, obtTime >= 16'h1234 && obtTime <= 16'h1235)
    conclude();
  end
endmodule
